/* File: csc_map.vh */
// Summary of operation
// - Fourth-order rate: clock over 4*1024*word
// - Third-order rate: clock over 3*1024*word
// - Settled result needs two output periods
// - Channel change resets modulator and filter
// - First result after change fully settled
// - Single channel: steady rate, no step detection
// - Step reflected from second result onward
// - Alternate polarity, average opposite conversions
// - Chop averaging adds odd half-rate notches
// - Dual notch select keeps output rate
// - Zero latency throughput is half the output rate
// - Order select bit one picks third order
// - Zero latency settles every conversion fully
`ifndef CSC_MAP_VH
`define CSC_MAP_VH
`define CSC_ADDR_W 3
`define CSC_REG_MODE 3'h0
`define CSC_REG_CHAN 3'h1
`define CSC_REG_DATA 3'h2
`define CSC_REG_STAT 3'h3
`define CSC_REG_MASK 3'h4
`define CSC_MODE_WORD_LSB 0
`define CSC_MODE_ORDER_BIT 10
`define CSC_MODE_ZLAT_BIT 11
`define CSC_MODE_REJ_BIT 12
`define CSC_MODE_RST 32'h0000_0060
`define CSC_BLOCK_LEN 1024
`define CSC_ORDER4 4
`define CSC_ORDER3 3
`define CSC_SETTLE_PERIODS 2
`define CSC_STAT_READY 0
`define CSC_STAT_OVR 1
`endif

/* File: csc_modclk.v */
`timescale 1ns/1ps
`default_nettype none
// Master clock enable derived from system clock by a fractional accumulator
module csc_modclk #(
  parameter [15:0] INC = 16'h0C98
) (
  input wire i_clock,
  input wire i_sys_rst,
  output reg o_tick
);
  reg [15:0] acc_q;
  wire [16:0] sum_d = {1'b0, acc_q} + {1'b0, INC};
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_q <= 16'h0000;
      o_tick <= 1'b0;
    end else begin
      acc_q <= sum_d[15:0];
      o_tick <= sum_d[16];
    end
  end
endmodule // csc_modclk
`default_nettype wire

/* File: csc_sync.v */
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; change accepted when stages two and three agree
module csc_sync #(
  parameter W = 16
) (
  input wire i_clock,
  input wire i_sys_rst,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync,
  output wire o_valid
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        o_sync <= s3_q;
    end
  end
  assign o_valid = (s2_q == s3_q);
endmodule // csc_sync
`default_nettype wire

/* File: csc_top.v */
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "csc_map.vh"
// Chopped sinc conversion timing and averaging control
module csc_top #(
  parameter DW = 24,
  parameter [15:0] MCLK_INC = 16'h0C98
) (
  input wire i_clock,
  input wire i_sys_rst,
  input wire [2:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire [DW-1:0] i_sample,
  output reg o_polarity,
  output reg o_filter_reset,
  output reg o_ready,
  output reg o_irq
);
  localparam ST_SETTLE = 2'b00;
  localparam ST_RUN = 2'b01;
  localparam ST_RESET = 2'b10;

  wire mclk_tick;
  wire [DW-1:0] sample_s;
  wire sample_ok;

  csc_modclk #(.INC(MCLK_INC)) u_mclk (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .o_tick(mclk_tick)
  );

  csc_sync #(.W(DW)) u_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async(i_sample),
    .o_sync(sample_s),
    .o_valid(sample_ok)
  );

  reg [31:0] mode_q;
  reg [3:0] chan_q;
  reg [DW-1:0] data_q;
  reg [1:0] stat_q;
  reg [1:0] mask_q;
  reg [1:0] state_q;
  reg [21:0] cnt_q;
  reg [1:0] conv_q;
  reg [DW:0] first_q;
  reg have_first_q;
  reg chan_chg_q;

  wire [9:0] rate_divider_word = mode_q[`CSC_MODE_WORD_LSB +: 10];
  wire third_order_filter_select = mode_q[`CSC_MODE_ORDER_BIT];
  wire zero_latency = mode_q[`CSC_MODE_ZLAT_BIT];
  // Notch select is only reported in the status readback; it does nothing else here
  wire dual_mains_notch_select = mode_q[`CSC_MODE_REJ_BIT];

  // Period in master clocks: order times block length times word
  wire [2:0] order = third_order_filter_select ? 3'd`CSC_ORDER3 :
    3'd`CSC_ORDER4;
  wire [9:0] word_eff = (rate_divider_word == 10'h000) ? 10'h001 :
    rate_divider_word;
  wire [21:0] period = {2'b00, word_eff, 10'h000} * {19'h0, order};
  wire period_end = mclk_tick && (cnt_q >= period - 22'h000001);
  // First result after a restart needs two periods of settling
  wire settled = (state_q == ST_RUN) ||
    (conv_q >= 2'd`CSC_SETTLE_PERIODS - 2'd1);

  // Signed sample extended one bit so the average cannot overflow
  wire [DW:0] s_ext = {sample_s[DW-1], sample_s};
  wire [DW:0] s_pol = o_polarity ? (~s_ext + {{DW{1'b0}}, 1'b1}) : s_ext;
  wire [DW:0] avg_sum = first_q + s_pol;
  wire [DW-1:0] avg = avg_sum[DW:1];

  wire rd_data = i_rd && (i_addr == `CSC_REG_DATA);
  wire rd_stat = i_rd && (i_addr == `CSC_REG_STAT);
  reg latch_now;
  reg [1:0] ev;

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_q <= `CSC_MODE_RST;
      chan_q <= 4'h0;
      chan_chg_q <= 1'b0;
      mask_q <= 2'b00;
    end else begin
      chan_chg_q <= 1'b0;
      if (i_wr && i_addr == `CSC_REG_MODE)
        mode_q <= i_wdata;
      if (i_wr && i_addr == `CSC_REG_CHAN) begin
        chan_q <= i_wdata[3:0];
        chan_chg_q <= (i_wdata[3:0] != chan_q);
      end
      if (i_wr && i_addr == `CSC_REG_MASK)
        mask_q <= i_wdata[1:0];
    end
  end

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ST_RESET;
      cnt_q <= 22'h000000;
      conv_q <= 2'b00;
      first_q <= {(DW+1){1'b0}};
      have_first_q <= 1'b0;
      o_polarity <= 1'b0;
      o_filter_reset <= 1'b1;
      data_q <= {DW{1'b0}};
      latch_now <= 1'b0;
    end else begin
      latch_now <= 1'b0;
      o_filter_reset <= 1'b0;
      if (chan_chg_q) begin
        state_q <= ST_RESET;
        o_filter_reset <= 1'b1;
      end else begin
        case (state_q)
          ST_RESET: begin
            cnt_q <= 22'h000000;
            conv_q <= 2'b00;
            have_first_q <= 1'b0;
            o_polarity <= 1'b0;
            state_q <= ST_SETTLE;
          end
          ST_SETTLE, ST_RUN: begin
            if (mclk_tick)
              cnt_q <= period_end ? 22'h000000 : cnt_q + 22'h000001;
            if (period_end) begin
              // Input steps are not sensed; only a channel change restarts the cadence
              if (have_first_q && sample_ok) begin
                // Settle interval counts two periods first time
                if (settled) begin
                  // Held result changes only when a newer one is latched
                  data_q <= avg;
                  latch_now <= 1'b1;
                  state_q <= zero_latency ? ST_SETTLE : ST_RUN;
                end
              end
              first_q <= s_pol;
              have_first_q <= 1'b1;
              o_polarity <= ~o_polarity;
              if (conv_q != 2'b11)
                conv_q <= conv_q + 2'b01;
              // Zero latency restarts the settle count after every result
              if (zero_latency && have_first_q && sample_ok && settled)
                conv_q <= 2'b00;
            end
          end
          default: state_q <= ST_RESET;
        endcase
      end
    end
  end

  always @* begin
    ev = 2'b00;
    ev[`CSC_STAT_READY] = latch_now;
    ev[`CSC_STAT_OVR] = latch_now && stat_q[`CSC_STAT_READY];
  end

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stat_q <= 2'b00;
      o_ready <= 1'b0;
      o_irq <= 1'b0;
      o_rdata <= 32'h0000_0000;
    end else begin
      // Set beats a clearing read in the same cycle
      stat_q <= (rd_stat ? 2'b00 : stat_q) | ev;
      if (latch_now)
        o_ready <= 1'b1;
      else if (rd_data)
        o_ready <= 1'b0;
      o_irq <= |(((rd_stat ? 2'b00 : stat_q) | ev) & mask_q);
      o_rdata <= 32'h0000_0000;
      if (i_rd) begin
        case (i_addr)
          `CSC_REG_MODE: o_rdata <= mode_q;
          `CSC_REG_CHAN: o_rdata <= {28'h0, chan_q};
          `CSC_REG_DATA: o_rdata <= {{(32-DW){1'b0}}, data_q};
          `CSC_REG_STAT: o_rdata <= {25'h0, dual_mains_notch_select,
            state_q, o_polarity, o_ready, stat_q};
          `CSC_REG_MASK: o_rdata <= {30'h0, mask_q};
          default: o_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // csc_top
`default_nettype wire

/* File: csc_src.sv */
`timescale 1ns/1ps
`default_nettype none
module csc_src #(
  parameter logic [23:0] OFS = 24'h3E8
) (
  input wire logic i_pol,
  input wire logic [23:0] i_val,
  output logic [23:0] o_sample
);
  // Offset that only the opposite-polarity average can cancel
  assign o_sample = i_pol ? OFS - i_val : OFS + i_val;
endmodule // csc_src
`default_nettype wire

/* File: csc_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module csc_chk (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [2:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_polarity,
  input wire logic o_filter_reset,
  input wire logic o_ready,
  input wire logic o_irq
);
  reg [10:0] md_q;
  reg [3:0] ch_q;
  reg [1:0] m_q;
  reg pl_q;
  reg [23:0] c_q, s_q;
  // Word zero runs as one, so the expected period must too
  wire [9:0] wd = md_q[9:0] == 10'h0 ? 10'h1 : md_q[9:0];
  wire [23:0] p = (md_q[10] ? 24'h3 : 24'h4) * {4'h0, wd, 10'h0};
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      md_q <= 11'h060;
      ch_q <= 4'h0;
      m_q <= 2'h0;
      pl_q <= 1'b0;
      c_q <= 24'h0;
      s_q <= 24'h0;
    end else begin
      pl_q <= o_polarity;
      c_q <= pl_q != o_polarity ? 24'h1 : c_q + 24'h1;
      s_q <= o_filter_reset ? 24'h0 : s_q + 24'h1;
      if (i_wr && i_addr == 3'h0)
        md_q <= i_wdata[10:0];
      if (i_wr && i_addr == 3'h1)
        ch_q <= i_wdata[3:0];
      if (i_wr && i_addr == 3'h4)
        m_q <= i_wdata[1:0];
    end
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_newch;
    i_wr && i_addr == 3'h1 && i_wdata[3:0] != ch_q;
  endsequence
  sequence s_pulse;
    o_filter_reset ##1 !o_filter_reset;
  endsequence
  property p_rdz; !i_rd |=> o_rdata == 32'h0; endproperty
  // A result latched beside the read sets the flag again; that case is exempt
  property p_clr; i_rd && i_addr == 3'h2 && !$changed(o_polarity)
    |=> !o_ready; endproperty
  property p_chg; s_newch |-> ##[1:2] o_filter_reset; endproperty
  property p_pls; $rose(o_filter_reset) |-> s_pulse; endproperty
  property p_set; $rose(o_ready) |-> s_q + 24'h4 >= 2 * p; endproperty
  // Skip toggles near a restart, whose spacing is not one period
  property p_per; $changed(o_polarity) && s_q >= 3 * p
    |-> c_q >= p && c_q <= p + 24'h2; endproperty
  property p_irq; $rose(o_ready) && m_q[0] |-> ##[0:2] o_irq; endproperty
  property p_msk; m_q == 2'h0 |=> !o_irq; endproperty
  a_rdz: assert property (p_rdz) else $error("rdata not idle");
  a_clr: assert property (p_clr) else $error("ready kept");
  a_chg: assert property (p_chg) else $error("no filter reset");
  a_pls: assert property (p_pls) else $error("reset too long");
  a_set: assert property (p_set) else $error("early result");
  a_per: assert property (p_per) else $error("bad period");
  a_irq: assert property (p_irq) else $error("irq missing");
  a_msk: assert property (p_msk) else $error("irq unmasked");
endmodule // csc_chk
`default_nettype wire

/* File: csc_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module csc_top_tb_top;
  logic i_clock = 1'b0;
  logic rst = 1'b1;
  logic [2:0] adr = 3'h0;
  logic [31:0] wd = 32'h0, r, rdat;
  logic wr = 1'b0, rd = 1'b0, pol, frst, rdy, irq;
  logic [23:0] val = 24'h0, smp;
  int n_mismatch = 0, num_checks = 0, cyc = 0, n, p, q;
  csc_top #(.MCLK_INC(16'hFFFF)) i_csc_top (.i_clock(i_clock),
    .i_sys_rst(rst), .i_addr(adr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdat), .i_sample(smp), .o_polarity(pol),
    .o_filter_reset(frst), .o_ready(rdy), .o_irq(irq));
  csc_src i_csc_src (.i_pol(pol), .i_val(val), .o_sample(smp));
  task automatic tally_and_finish;
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wrt(input logic [2:0] a, input logic [31:0] d);
    @(posedge i_clock);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask
  task automatic rdt(input logic [2:0] a);
    @(posedge i_clock);
    adr <= a;
    rd <= 1'b1;
    @(posedge i_clock);
    rd <= 1'b0;
    #1 r = rdat;
  endtask
  // Bounded wait; the count doubles as the measured interval
  task automatic wt;
    n = 0;
    while (rdy !== 1'b1 && n < 20000) begin
      @(posedge i_clock);
      #1 n++;
    end
  endtask
  initial forever #5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge i_clock);
    rst <= 1'b0;
    rdt(3'h0);
    chk(r, 32'h60);
    rdt(3'h5);
    chk(r, 32'h0);
    // Fourth order at word one, then third order at word two and at word one;
    // the last pass runs zero latency, one result per two periods
    for (int k = 0; k < 3; k++) begin
      p = k == 0 ? 4096 : 6144;
      q = k == 2 ? p : 2 * p;
      wrt(3'h0, k == 0 ? 32'h1 : k == 1 ? 32'h402 : 32'h1C01);
      wrt(3'h4, k % 2);
      // Clear status left by the previous pass so the checks below bite
      rdt(3'h3);
      val <= 24'h100 + k;
      wrt(3'h1, k + 1);
      wt;
      chk(n >= q - 8 && n <= q + 16, 1);
      #20 chk(irq, k % 2);
      rdt(3'h3);
      chk(r[0], 1);
      #20 chk(irq, 0);
      rdt(3'h2);
      chk(r, 32'h100 + k);
      val <= 24'h200 + k;
      repeat (3) begin
        wt;
        chk(n >= p - 40 && n <= p + 2, 1);
        rdt(3'h2);
      end
      chk(r, 32'h200 + k);
    end
    tally_and_finish();
  end
endmodule // csc_top_tb_top
bind csc_top csc_chk i_csc_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_polarity(o_polarity),
  .o_filter_reset(o_filter_reset), .o_ready(o_ready), .o_irq(o_irq));
`default_nettype wire
